// ==== test/can_mode_control_bench.sv ====
module can_mode_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cmc_pkg::*;
   localparam int          BIT_CYC = 4;
   localparam logic [31:0] ALL     = 32'hffffffff;
   logic            clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, serr;
   logic            eng_tx, cpu_stop, cpu_wait, dom, bit_tick, can_rx, can_tx, eng_run, eng_abort;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic [2:0]      tx_done, abort_ack, abort_req;
   logic [15:0]     bit_timing;
   cmc_eng_status_t st;
   int              n_errors = 0, num_checks = 0, cyc = 0;
   // Device and the bus it sits on
   cmc_top dut (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BIT_TICK(bit_tick), .ENG_TX_BIT(eng_tx), .ENG_STATUS(st), .TX_DONE(tx_done),
      .ABORT_ACK(abort_ack), .ENG_RUN(eng_run), .ENG_ABORT(eng_abort), .ABORT_REQ(abort_req),
      .BIT_TIMING(bit_timing), .CPU_STOP(cpu_stop), .CPU_WAIT(cpu_wait), .CAN_RX(can_rx),
      .CAN_TX(can_tx)
   );
   cmc_bus_model #(.BIT_CYC(BIT_CYC)) u_bus (
      .clk(clk_sys), .rst_n(rst_n), .dom(dom), .can_tx(can_tx), .bit_tick(bit_tick),
      .can_rx(can_rx)
   );
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Runaway guard, far above the bus-off recovery time
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
      num_checks++;
      if ((got & msk) !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got & msk, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp}, 32'h1);
   endtask : chkb
   // One APB transfer; request held until pready is seen, then released
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      serr = pslverr;
      {psel, penable} <= 2'b00;
      #1;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, msk);
   endtask : rdc
   // Sampling lands 1 ns after the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic wait_run(input int m);
      repeat (m) if (eng_run !== 1'b1) tick(1);
   endtask : wait_run
   task automatic t_reset();
      chkb(can_tx, 1'b1);
      rdc(OFF_CTL0, 32'h01, ALL);
      rdc(OFF_CTL1, 32'h01, ALL);
      rdc(OFF_TFLG, 32'h07, ALL);
      rdc(8'hfc, 32'h0, ALL);
      chkb(serr, 1'b1);
      wr(OFF_BTR0, 32'h5a);
      wr(OFF_BTR1, 32'ha5);
      chk({16'h0, bit_timing}, 32'ha55a, ALL);
   endtask : t_reset
   // A dominant bus holds resync off; the eleventh recessive bit releases it
   task automatic t_exit();
      dom <= 1'b1;
      wr(OFF_CTL0, 32'h0);
      tick(20 * BIT_CYC);
      chkb(eng_run, 1'b0);
      dom <= 1'b0;
      tick(10 * BIT_CYC);
      chkb(eng_run, 1'b0);
      wait_run(4 * BIT_CYC);
      chkb(eng_run, 1'b1);
      rdc(OFF_CTL1, 32'h0, ALL);
      rdc(OFF_ERR, 32'h2112, ALL);
      wr(OFF_BTR0, 32'h33);
      chk({16'h0, bit_timing}, 32'ha55a, ALL);
   endtask : t_exit
   // Init request in mid-traffic
   task automatic t_init();
      wr(OFF_CTL0, 32'h24);
      wr(OFF_TFLG, 32'h1);
      wr(OFF_TARQ, 32'h1);
      chk({29'h0, abort_req}, 32'h1, ALL);
      chkb(can_tx, 1'b0);
      wr(OFF_CTL0, 32'h25);
      chkb(can_tx, 1'b1);
      tick(2);
      chkb(eng_abort, 1'b1);
      rdc(OFF_CTL1, 32'h01, ALL);
      rdc(OFF_CTL0, 32'h05, 32'h27);
      rdc(OFF_TFLG, 32'h07, ALL);
      rdc(OFF_RFLG, 32'h28, ALL);
      chk({29'h0, abort_req}, 32'h0, ALL);
      wr(OFF_CTL0, 32'h0);
      wait_run(20 * BIT_CYC);
   endtask : t_init
   // Sleep waits for idle, holds a clear until entered, wakes on traffic
   task automatic t_sleep();
      eng_tx <= 1'b1;
      st.rx_busy <= 1'b1;
      wr(OFF_RIER, 32'h80);
      wr(OFF_CTL0, 32'h04);
      wr(OFF_CTL0, 32'h06);
      tick(4);
      rdc(OFF_CTL1, 32'h0, ALL);
      wr(OFF_CTL0, 32'h04);
      rdc(OFF_CTL0, 32'h06, 32'h07);
      wr(OFF_TFLG, 32'h1);
      st.rx_busy <= 1'b0;
      tick(3);
      rdc(OFF_CTL1, 32'h0, ALL);
      tx_done <= 3'h1;
      tick(1);
      tx_done <= 3'h0;
      tick(3);
      rdc(OFF_CTL1, 32'h02, ALL);
      dom <= 1'b1;
      tick(2 * BIT_CYC);
      dom <= 1'b0;
      rdc(OFF_RFLG, 32'h80, 32'h80);
      rdc(OFF_CTL0, 32'h0, 32'h02);
      wr(OFF_CTL0, 32'h06);
      rdc(OFF_CTL0, 32'h0, 32'h02);
      wr(OFF_RFLG, 32'h80);
      rdc(OFF_RFLG, 32'h0, 32'h80);
      wait_run(20 * BIT_CYC);
      chkb(eng_run, 1'b1);
   endtask : t_sleep
   // Stop, or wait with stop_in_wait, forces the pin recessive
   task automatic t_stop();
      eng_tx <= 1'b0;
      tick(2);
      chkb(can_tx, 1'b0);
      cpu_stop <= 1'b1;
      tick(2);
      chkb(can_tx, 1'b1);
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b1;
      tick(2);
      chkb(can_tx, 1'b0);
      wr(OFF_CTL0, 32'h20);
      tick(2);
      chkb(can_tx, 1'b1);
      cpu_wait <= 1'b0;
   endtask : t_stop
   // Sleep first, then init; bus-off recovery takes 128 runs of 11 recessive bits
   task automatic t_busoff();
      eng_tx <= 1'b1;
      wr(OFF_CTL0, 32'h02);
      tick(3);
      rdc(OFF_CTL1, 32'h02, ALL);
      wr(OFF_CTL0, 32'h03);
      tick(2);
      st.bus_off <= 1'b1;
      wr(OFF_CTL0, 32'h02);
      tick(11 * 127 * BIT_CYC);
      chkb(eng_run, 1'b0);
      wait_run(30 * BIT_CYC);
      chkb(eng_run, 1'b1);
      rdc(OFF_CTL1, 32'h02, ALL);
   endtask : t_busoff
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {eng_tx, cpu_stop, cpu_wait, dom, tx_done, abort_ack} = '0;
      st = 22'h0a2112;
      rst_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_exit();
      t_init();
      t_sleep();
      t_stop();
      t_busoff();
      print_verdict();
   end
endmodule : can_mode_control_bench

// ==== test/cmc_bus_model.sv ====
module cmc_bus_model #(
   parameter int BIT_CYC = 4
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Other node and the bus
   input  wire logic dom,
   input  wire logic can_tx,
   output logic      bit_tick,
   output logic      can_rx
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt_r;
   // One sample point each bit time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_r <= 0;
      else cnt_r <= (cnt_r == BIT_CYC - 1) ? 0 : cnt_r + 1;
   end
   // Wired-AND bus: recessive unless some node pulls it dominant
   assign bit_tick = (cnt_r == BIT_CYC - 1);
   assign can_rx   = can_tx & ~dom;
endmodule : cmc_bus_model

// ==== test/cmc_props.sv ====
module cmc_props
   import cmc_pkg::*;
(
   // Clock, reset and APB
   input wire logic                     CLK_SYS,
   input wire logic                     RST_N,
   input wire logic                     PSEL,
   input wire logic                     PENABLE,
   input wire logic                     PWRITE,
   input wire logic [7:0]               PADDR,
   input wire logic [31:0]              PWDATA,
   // Engine side, CPU state and pins
   input wire logic                     BIT_TICK,
   input wire cmc_pkg::cmc_eng_status_t ENG_STATUS,
   input wire logic                     ENG_RUN,
   input wire logic                     ENG_ABORT,
   input wire logic [2:0]               ABORT_REQ,
   input wire logic [15:0]              BIT_TIMING,
   input wire logic                     CPU_STOP,
   input wire logic                     CAN_RX,
   input wire logic                     CAN_TX
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   logic       wr_c0;
   logic       wr_bt;
   logic [7:0] run_r;
   // Write strobes of the access phase
   assign wr_c0 = PSEL && PENABLE && PWRITE && PADDR == OFF_CTL0;
   assign wr_bt = PSEL && PENABLE && PWRITE && (PADDR == OFF_BTR0 || PADDR == OFF_BTR1);
   // Recessive run length; saturates so a long idle bus never wraps to a short run
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) run_r <= 8'h00;
      else if (BIT_TICK && !CAN_RX) run_r <= 8'h00;
      else if (BIT_TICK && run_r != 8'hff) run_r <= run_r + 8'h01;
   end
   a_tx_init: assert property (wr_c0 && PWDATA[CTL0_INIT_REQ] |=> CAN_TX)
      else $error("tx pin not recessive at init request");
   a_tx_stop: assert property (CPU_STOP |=> CAN_TX)
      else $error("tx pin not recessive in stop");
   a_tx_idle: assert property (!ENG_RUN [*2] |-> CAN_TX)
      else $error("tx pin driven outside normal mode");
   a_init_enter: assert property (wr_c0 && PWDATA[CTL0_INIT_REQ] |-> ##2 ENG_ABORT && !ENG_RUN)
      else $error("init mode not entered");
   a_abort_clear: assert property ($rose(ENG_ABORT) |-> ABORT_REQ == 3'h0)
      else $error("abort requests kept over init entry");
   a_timing_lock: assert property (!$stable(BIT_TIMING) |-> $past(wr_bt && ENG_ABORT))
      else $error("bit timing changed while locked");
   a_resync_count: assert property ($rose(ENG_RUN) |-> run_r >= 8'h0b)
      else $error("resync before eleven recessive bits");
   a_sleep_idle: assert property ($fell(ENG_RUN) && !ENG_ABORT |-> !$past(ENG_STATUS.rx_busy))
      else $error("sleep entered while receiving");
endmodule : cmc_props

bind cmc_top cmc_props u_props (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .BIT_TICK(BIT_TICK), .ENG_STATUS(ENG_STATUS),
   .ENG_RUN(ENG_RUN), .ENG_ABORT(ENG_ABORT), .ABORT_REQ(ABORT_REQ),
   .BIT_TIMING(BIT_TIMING), .CPU_STOP(CPU_STOP), .CAN_RX(CAN_RX), .CAN_TX(CAN_TX)
);

// ==== verilog/cmc_pkg.sv ====
package cmc_pkg;

   // Register byte offsets on the APB side
   localparam logic [7:0] OFF_CTL0  = 8'h00;
   localparam logic [7:0] OFF_CTL1  = 8'h04;
   localparam logic [7:0] OFF_RFLG  = 8'h08;
   localparam logic [7:0] OFF_RIER  = 8'h0c;
   localparam logic [7:0] OFF_TFLG  = 8'h10;
   localparam logic [7:0] OFF_TIER  = 8'h14;
   localparam logic [7:0] OFF_TARQ  = 8'h18;
   localparam logic [7:0] OFF_TAAK  = 8'h1c;
   localparam logic [7:0] OFF_TBSEL = 8'h20;
   localparam logic [7:0] OFF_BTR0  = 8'h24;
   localparam logic [7:0] OFF_BTR1  = 8'h28;
   localparam logic [7:0] OFF_IDAC  = 8'h2c;
   localparam logic [7:0] OFF_IDAR0 = 8'h30;
   localparam logic [7:0] OFF_IDMR0 = 8'h50;
   localparam logic [7:0] OFF_ERR   = 8'h70;

   // Field positions
   localparam int CTL0_INIT_REQ  = 0;
   localparam int CTL0_SLEEP_REQ = 1;
   localparam int CTL0_WAKE_EN   = 2;
   localparam int CTL0_SYNCED    = 4;
   localparam int CTL0_STOP_WAIT = 5;
   localparam int CTL0_RX_ACT    = 6;
   localparam int CTL1_INIT_ACK  = 0;
   localparam int CTL1_SLEEP_ACK = 1;
   localparam int RFLG_WAKE_FLAG = 7;
   localparam int RFLG_RXST_LO   = 4;
   localparam int RIER_WAKE_IE   = 7;
   localparam int RIER_TXST_LO   = 2;

   // Sizes and reset values
   localparam int         NUM_TXBUF  = 3;
   localparam int         NUM_ID     = 8;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [2:0] RST_TFLG   = 3'h7;

   // Resynchronisation counts: recessive run in bit times, bus-off in runs
   localparam logic [3:0] RECESSIVE_RUN = 4'hb;
   localparam logic [7:0] BUSOFF_RUNS   = 8'h80;

   // Status from the protocol engine
   typedef struct packed {
      logic       rx_busy;
      logic       bus_off;
      logic [1:0] tx_state;
      logic [1:0] rx_state;
      logic [7:0] tec;
      logic [7:0] rec;
   } cmc_eng_status_t;

   // Operating modes
   typedef enum logic [3:0] {
      ST_NORMAL = 4'b0001,
      ST_SLEEP  = 4'b0010,
      ST_INIT   = 4'b0100,
      ST_RESYNC = 4'b1000
   } cmc_mode_t;

   // Address match of one register word
   function automatic logic cmc_hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction : cmc_hit

endpackage : cmc_pkg

// ==== verilog/cmc_resync.sv ====
module cmc_resync
   import cmc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic start,
   input  wire logic bit_tick,
   input  wire logic rx_bit,
   input  wire logic bus_off,
   // Result
   output logic      done
);

   logic [3:0] run_r;
   logic [7:0] occ_r;
   logic       done_r;

   assign done = done_r;

   // Count runs of recessive bits; a dominant bit restarts the run
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r  <= 4'h0;
         occ_r  <= 8'h00;
         done_r <= 1'b0;
      end else if (start) begin
         run_r  <= 4'h0;
         occ_r  <= 8'h00;
         done_r <= 1'b0;
      end else if (bit_tick && !done_r) begin
         if (!rx_bit) begin
            run_r <= 4'h0;
         end else if (run_r == RECESSIVE_RUN - 4'h1) begin
            run_r <= 4'h0;
            occ_r <= occ_r + 8'h01;
            // Bus-off needs many runs before rejoining the bus
            if (!bus_off || (occ_r == BUSOFF_RUNS - 8'h01)) begin
               done_r <= 1'b1;
            end
         end else begin
            run_r <= run_r + 4'h1;
         end
      end
   end

endmodule : cmc_resync

// ==== verilog/cmc_top.sv ====
// Functional notes
// - Wake enable lets bus traffic end sleep
// - Sleep entered only when bus idle
// - Sleep acknowledge set on sleep entry
// - Sleep request refused while wake flag set
// - Sleep ends by CPU clear or wake
// - Init request enters init at once, aborting
// - Init acknowledge set on init entry
// - Init entry resets status and tx registers
// - Init keeps wake, sleep, init request bits
// - Tx and rx state fields survive init; in RIER only the tx state field does
// - Config writes only while init acknowledged
// - Error counters survive init entry, exit
// - Resync after 11 recessive, bus-off 128 times
// - Sleep request clear ignored until acknowledged
// - Init request clear ignored until acknowledged
// - Tx pin recessive at init request
// - Tx pin recessive in stop, wait (wait only when stop-in-wait is set)
//
// The address map and the APB register port were left to the implementer.
module cmc_top (
   // Clock and reset
   input  wire logic                     CLK_SYS,
   input  wire logic                     RST_N,
   // APB slave
   input  wire logic                     PSEL,
   input  wire logic                     PENABLE,
   input  wire logic                     PWRITE,
   input  wire logic [7:0]               PADDR,
   input  wire logic [31:0]              PWDATA,
   output logic      [31:0]              PRDATA,
   output logic                          PREADY,
   output logic                          PSLVERR,
   // Protocol engine side
   input  wire logic                     BIT_TICK,
   input  wire logic                     ENG_TX_BIT,
   input  wire cmc_pkg::cmc_eng_status_t ENG_STATUS,
   input  wire logic [2:0]               TX_DONE,
   input  wire logic [2:0]               ABORT_ACK,
   output logic                          ENG_RUN,
   output logic                          ENG_ABORT,
   output logic      [2:0]               ABORT_REQ,
   output logic      [15:0]              BIT_TIMING,
   // CPU low-power state
   input  wire logic                     CPU_STOP,
   input  wire logic                     CPU_WAIT,
   // CAN pins
   input  wire logic                     CAN_RX,
   output logic                          CAN_TX
);
   import cmc_pkg::*;

   cmc_mode_t  mode_r, mode_nxt;
   logic       init_req_r, init_req_nxt;
   logic       sleep_req_r, sleep_req_nxt;
   logic       wake_en_r, stop_wait_r, wake_armed_r;
   logic       wake_flag_r;
   logic [2:0] rflg_misc_r;
   logic [1:0] rx_state_r, tx_state_r;
   logic       wake_ie_r;
   logic [1:0] txst_ie_r;
   logic [4:0] rier_misc_r;
   logic [2:0] tflg_r, tier_r, tarq_r, taak_r;
   logic [2:0] tbsel_r;
   logic [7:0] btr0_r, btr1_r, idac_r;
   logic [7:0] idar_r [NUM_ID];
   logic [7:0] idmr_r [NUM_ID];
   logic [31:0] prdata_r, rd_nxt;
   logic       tx_r;
   logic       wr, hit, init_ack, sleep_ack, cfg_open, bus_idle;
   logic       init_entry, sleep_entry, wake_evt, resync_done;
   logic [7:0] wd;

   assign wd        = PWDATA[7:0];
   assign wr        = PSEL && PENABLE && PWRITE;
   assign init_ack  = (mode_r == ST_INIT);
   assign sleep_ack = (mode_r == ST_SLEEP);
   assign cfg_open  = init_req_r && init_ack;
   // Idle: nothing arriving and every transmit buffer empty
   assign bus_idle  = !ENG_STATUS.rx_busy && (tflg_r == RST_TFLG);
   // Dominant level while asleep counts as bus activity
   assign wake_evt  = sleep_ack && wake_armed_r && !CAN_RX;

   // Request bits: refused sets and premature clears are dropped
   always_comb begin
      init_req_nxt  = init_req_r;
      sleep_req_nxt = sleep_req_r;
      if (wr && cmc_hit(PADDR, OFF_CTL0)) begin
         if (wd[CTL0_INIT_REQ] || init_ack) begin
            init_req_nxt = wd[CTL0_INIT_REQ];
         end
         if (wd[CTL0_SLEEP_REQ] && !sleep_req_r && !wake_flag_r) begin
            sleep_req_nxt = 1'b1;
         end else if (!wd[CTL0_SLEEP_REQ] && sleep_ack) begin
            sleep_req_nxt = 1'b0;
         end
      end
      if (wake_evt) begin
         sleep_req_nxt = 1'b0;
      end
   end

   // Mode sequencing; an init request overrides every other mode
   always_comb begin
      case (mode_r)
         ST_NORMAL: mode_nxt = sleep_req_r && bus_idle ? ST_SLEEP : ST_NORMAL;
         ST_SLEEP:  mode_nxt = sleep_req_r ? ST_SLEEP : ST_RESYNC;
         ST_INIT:   mode_nxt = init_req_r ? ST_INIT : ST_RESYNC;
         ST_RESYNC: mode_nxt = resync_done ? ST_NORMAL : ST_RESYNC;
         default:   mode_nxt = ST_INIT;
      endcase
      if (init_req_r) begin
         mode_nxt = ST_INIT;
      end
   end

   assign init_entry  = (mode_r != ST_INIT) && (mode_nxt == ST_INIT);
   assign sleep_entry = (mode_r != ST_SLEEP) && (mode_nxt == ST_SLEEP);

   // Mode and request registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mode_r      <= ST_INIT;
         init_req_r  <= 1'b1;
         sleep_req_r <= 1'b0;
      end else begin
         mode_r      <= mode_nxt;
         init_req_r  <= init_req_nxt;
         sleep_req_r <= sleep_req_nxt;
      end
   end

   // Other control bits; stop-in-wait is the only one init clears
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wake_en_r    <= 1'b0;
         stop_wait_r  <= 1'b0;
         wake_armed_r <= 1'b0;
      end else begin
         if (wr && cmc_hit(PADDR, OFF_CTL0)) begin
            wake_en_r   <= wd[CTL0_WAKE_EN];
            stop_wait_r <= wd[CTL0_STOP_WAIT];
         end
         if (init_entry) begin
            stop_wait_r <= 1'b0;
         end
         // Wake choice frozen at sleep entry; later edits wait
         if (sleep_entry) begin
            wake_armed_r <= wake_en_r;
         end
      end
   end

   // Receiver flags: wake flag is write-one-to-clear, set wins
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wake_flag_r <= 1'b0;
         rflg_misc_r <= 3'h0;
         rx_state_r  <= 2'h0;
         tx_state_r  <= 2'h0;
      end else begin
         // Both status fields track the engine, so init cannot clear them
         rx_state_r <= ENG_STATUS.rx_state;
         tx_state_r <= ENG_STATUS.tx_state;
         if (init_entry) begin
            wake_flag_r <= 1'b0;
            rflg_misc_r <= 3'h0;
         end else if (wake_evt) begin
            wake_flag_r <= 1'b1;
         end else if (wr && cmc_hit(PADDR, OFF_RFLG) && wd[RFLG_WAKE_FLAG]) begin
            wake_flag_r <= 1'b0;
         end
      end
   end

   // Receiver interrupt enables; the tx state field is kept
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wake_ie_r   <= 1'b0;
         txst_ie_r   <= 2'h0;
         rier_misc_r <= 5'h00;
      end else if (init_entry) begin
         wake_ie_r   <= 1'b0;
         rier_misc_r <= 5'h00;
      end else if (wr && cmc_hit(PADDR, OFF_RIER)) begin
         wake_ie_r   <= wd[RIER_WAKE_IE];
         txst_ie_r   <= wd[RIER_TXST_LO +: 2];
         rier_misc_r <= {wd[6:4], wd[1:0]};
      end
   end

   // Transmit buffers: cpu queues by writing one, engine frees
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tflg_r  <= RST_TFLG;
         tier_r  <= 3'h0;
         tarq_r  <= 3'h0;
         taak_r  <= 3'h0;
         tbsel_r <= 3'h0;
      end else if (init_entry) begin
         tflg_r  <= RST_TFLG;
         tier_r  <= 3'h0;
         tarq_r  <= 3'h0;
         taak_r  <= 3'h0;
         tbsel_r <= 3'h0;
      end else begin
         // Freeing in the same cycle as a queue write wins
         tflg_r <= (tflg_r & ~((wr && cmc_hit(PADDR, OFF_TFLG)) ? wd[2:0] : 3'h0))
                   | TX_DONE | ABORT_ACK;
         taak_r <= (taak_r & ~((wr && cmc_hit(PADDR, OFF_TFLG)) ? wd[2:0] : 3'h0))
                   | ABORT_ACK;
         if (wr && cmc_hit(PADDR, OFF_TARQ)) begin
            tarq_r <= (wd[2:0] & ~tflg_r) & ~ABORT_ACK;
         end else begin
            tarq_r <= tarq_r & ~ABORT_ACK & ~tflg_r;
         end
         if (wr && cmc_hit(PADDR, OFF_TIER)) begin
            tier_r <= wd[2:0];
         end
         if (wr && cmc_hit(PADDR, OFF_TBSEL)) begin
            tbsel_r <= wd[2:0];
         end
      end
   end

   // Configuration, locked unless init is requested and acknowledged
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         btr0_r <= RST_BYTE;
         btr1_r <= RST_BYTE;
         idac_r <= RST_BYTE;
         for (int i = 0; i < NUM_ID; i++) begin
            idar_r[i] <= RST_BYTE;
            idmr_r[i] <= RST_BYTE;
         end
      end else if (wr && cfg_open) begin
         if (cmc_hit(PADDR, OFF_BTR0)) btr0_r <= wd;
         if (cmc_hit(PADDR, OFF_BTR1)) btr1_r <= wd;
         if (cmc_hit(PADDR, OFF_IDAC)) idac_r <= wd;
         for (int i = 0; i < NUM_ID; i++) begin
            if (cmc_hit(PADDR, OFF_IDAR0 + 8'(4 * i))) idar_r[i] <= wd;
            if (cmc_hit(PADDR, OFF_IDMR0 + 8'(4 * i))) idmr_r[i] <= wd;
         end
      end
   end

   // Read decode; error counters come straight from the engine
   always_comb begin
      rd_nxt = 32'h0000_0000;
      hit    = 1'b1;
      case (PADDR)
         OFF_CTL0:  rd_nxt[7:0] = {1'b0, ENG_STATUS.rx_busy, stop_wait_r, mode_r == ST_NORMAL,
                                   1'b0, wake_en_r, sleep_req_r, init_req_r};
         OFF_CTL1:  rd_nxt[7:0] = {6'h00, sleep_ack, init_ack};
         OFF_RFLG:  rd_nxt[7:0] = {wake_flag_r, rflg_misc_r[2], rx_state_r, tx_state_r,
                                   rflg_misc_r[1:0]};
         OFF_RIER:  rd_nxt[7:0] = {wake_ie_r, rier_misc_r[4:2], txst_ie_r, rier_misc_r[1:0]};
         OFF_TFLG:  rd_nxt[2:0] = tflg_r;
         OFF_TIER:  rd_nxt[2:0] = tier_r;
         OFF_TARQ:  rd_nxt[2:0] = tarq_r;
         OFF_TAAK:  rd_nxt[2:0] = taak_r;
         OFF_TBSEL: rd_nxt[2:0] = tbsel_r;
         OFF_BTR0:  rd_nxt[7:0] = btr0_r;
         OFF_BTR1:  rd_nxt[7:0] = btr1_r;
         OFF_IDAC:  rd_nxt[7:0] = idac_r;
         OFF_ERR:   rd_nxt[15:0] = {ENG_STATUS.tec, ENG_STATUS.rec};
         default: begin
            hit = 1'b0;
            for (int i = 0; i < NUM_ID; i++) begin
               if (cmc_hit(PADDR, OFF_IDAR0 + 8'(4 * i))) begin
                  rd_nxt[7:0] = idar_r[i];
                  hit         = 1'b1;
               end
               if (cmc_hit(PADDR, OFF_IDMR0 + 8'(4 * i))) begin
                  rd_nxt[7:0] = idmr_r[i];
                  hit         = 1'b1;
               end
            end
         end
      endcase
   end

   // Read data is captured in the setup cycle, so no wait state
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         prdata_r <= 32'h0000_0000;
      end else if (PSEL && !PENABLE) begin
         prdata_r <= PWRITE ? 32'h0000_0000 : rd_nxt;
      end
   end

   assign PRDATA  = prdata_r;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;

   // Transmit pin follows the engine only when fully online
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tx_r <= 1'b1;
      end else if (init_req_nxt || init_req_r) begin
         tx_r <= 1'b1;
      end else if (CPU_STOP || (CPU_WAIT && stop_wait_r)) begin
         tx_r <= 1'b1;
      end else begin
         tx_r <= (mode_r == ST_NORMAL) ? ENG_TX_BIT : 1'b1;
      end
   end

   assign CAN_TX     = tx_r;
   assign ENG_RUN    = (mode_r == ST_NORMAL);
   assign ENG_ABORT  = init_ack;
   assign ABORT_REQ  = tarq_r;
   assign BIT_TIMING = {btr1_r, btr0_r};

   // Rejoin the bus after recessive runs; restarted on every resync
   cmc_resync u_resync (
      .clk      (CLK_SYS),
      .rst_n    (RST_N),
      .start    (mode_r != ST_RESYNC),
      .bit_tick (BIT_TICK),
      .rx_bit   (CAN_RX),
      .bus_off  (ENG_STATUS.bus_off),
      .done     (resync_done)
   );

endmodule : cmc_top
